// ### common/flash_cmd_map.svh
// Purpose: Offsets, codes, field positions and reset values for the
//          flash special command engine.
// Assumes: Included by its bare name; definitions only.
// Notes:   Security encodings are held here so that software models agree.
//
// Overview of operation
// - One-time program: code 0x43, record index byte 1, data bytes 4-7.
// - One-time program checks record erased, writes, then reads back.
// - Record not all ones gives access error and no programming.
// - Record index above 0x0F gives access error.
// - Reads of the record's flash block are invalid while programming.
// - Any post-operation verify failure sets the verify-fail flag.
// - Completion flag sets when any command ends, error or not.
// - Command not allowed in current mode and security gives access error.
// - Code 0x44 erases whole array then verifies it erased.
// - Code 0x44 aborts with protection violation if anything protected.
// - Clean whole erase makes security unsecure; config field ends erased.
// - External erase ignores protection; on pass unsecures and programs byte.
// - Erase-all-request flag holds during external erase, clears at end.
// - Key verify 0x45 compares bytes 4-0xB, reversed within each group.
// - Key verify with backdoor disabled gives access error, no compare.
// - Key match unsecures; mismatch locks later key verifies out.
// - All-zero or all-one supplied key gives access error.
// - Code 0x49 erases, verifies, unsecures, programs security byte.
// - Completion flag held clear in reset; running command is aborted.
// - Security register loads from stored security byte after reset.
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

`define CODE_PROG_ONCE  8'h43
`define CODE_ERASE_ALL  8'h44
`define CODE_KEY_VERIFY 8'h45
`define CODE_ERASE_UNS  8'h49
`define MAX_RECORD      8'h0F

`define COB_CODE        0
`define COB_INDEX       1
`define COB_DATA0       4
`define COB_KEY0        4
`define COB_COUNT       12

`define SEC_LSB         0
`define BACKDOOR_KEY_ENABLE_LSB       6
`define SEC_UNSECURE    2'h2
`define BACKDOOR_KEY_ENABLE_ENABLED   2'h2
`define SEC_BYTE_UNSEC  8'hFE
`define SEC_RESET       2'h3
`define ERASED_WORD     32'hFFFFFFFF

`endif

// ### common/flash_cmd_pkg.sv
// Purpose: Types for the flash special command engine.
// Assumes: Used by scoped name only.
// Notes:   One-hot state codes are written out.
`default_nettype none
package flash_cmd_pkg;

  typedef enum logic [9:0] {
    ST_RESET    = 10'h001,
    ST_IDLE     = 10'h002,
    ST_RD_REC   = 10'h004,
    ST_PROG     = 10'h008,
    ST_PROG_VFY = 10'h010,
    ST_ERASE    = 10'h020,
    ST_ERS_VFY  = 10'h040,
    ST_PROG_SEC = 10'h080,
    ST_WAIT     = 10'h100,
    ST_DONE     = 10'h200
  } engine_state_t;

  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_READ_REC  = 3'h1,
    OP_PROG_REC  = 3'h2,
    OP_ERASE_ALL = 3'h3,
    OP_VFY_ALL   = 3'h4,
    OP_PROG_SEC  = 3'h5
  } array_op_t;

endpackage
`default_nettype wire

// ### logic/flash_special_command_engine.sv
// Purpose: Sequencer for one-time program, whole erase, key verify and
//          erase-unsecure flash commands.
// Assumes: Array controller runs on mclk and pulses array_done.
// Notes:   Launch is a one-cycle command_complete_flag_clear pulse while the flag is set.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"
module flash_special_command_engine #(
  parameter int COB_BYTES = `COB_COUNT
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        cob_write,
  input  wire logic [3:0]  cob_index,
  input  wire logic [7:0]  cob_wdata,
  input  wire logic        command_complete_flag_clear,
  input  wire logic        access_error_flag_clear,
  input  wire logic        protection_violation_flag_clear,
  input  wire logic        nvm_special_mode,
  input  wire logic        any_region_protected,
  input  wire logic [7:0]  stored_security_byte,
  input  wire logic [63:0] stored_backdoor_key,
  input  wire logic        ext_erase_pin,
  input  wire logic        array_done,
  input  wire logic        array_fail,
  input  wire logic [31:0] array_rdata,
  output logic             command_complete_flag,
  output logic             access_error_flag,
  output logic             protection_violation_flag,
  output logic             verify_fail_flag,
  output logic             erase_all_request_flag,
  output logic [1:0]       security_state_field,
  output logic             backdoor_key_enable,
  output logic             read_invalid,
  output logic             array_start,
  output flash_cmd_pkg::array_op_t array_op,
  output logic [3:0]       array_record,
  output logic [31:0]      array_wdata,
  output logic [7:0]       command_code_byte
);

  initial begin
    if (COB_BYTES < `COB_COUNT) begin
      $error("COB_BYTES too small for key verify");
    end
  end

  flash_cmd_pkg::engine_state_t state;
  flash_cmd_pkg::engine_state_t next_state;
  flash_cmd_pkg::engine_state_t after_wait;
  flash_cmd_pkg::engine_state_t next_after_wait;
  flash_cmd_pkg::array_op_t     next_array_op;
  logic [7:0] command_object_bytes [COB_BYTES];
  logic [7:0] next_cob [COB_BYTES];
  logic       next_command_complete_flag;
  logic       next_access_error_flag;
  logic       next_protection_violation_flag;
  logic       next_mgstat;
  logic       next_erase_all_request_flag;
  logic [1:0] next_sec;
  logic       key_lockout;
  logic       next_lockout;
  logic       ext_run;
  logic       next_ext_run;
  logic       next_start;
  logic       next_rd_inv;
  logic       ext_meta;
  logic       ext_sync;
  logic       ext_prev;
  logic [63:0] supplied_key;
  logic        launch;
  logic        ext_launch;
  logic        sec_secure;
  logic        key_match;

  // Key bytes map to config offsets reversed within each 4-byte group
  function automatic logic [63:0] gather_key(
    input logic [7:0] b4, input logic [7:0] b5,
    input logic [7:0] b6, input logic [7:0] b7,
    input logic [7:0] b8, input logic [7:0] b9,
    input logic [7:0] ba, input logic [7:0] bb);
    gather_key = {b8, b9, ba, bb, b4, b5, b6, b7};
  endfunction

  function automatic logic code_allowed(input logic [7:0] code,
                                        input logic special,
                                        input logic secure);
    logic known;
    known = (code == `CODE_PROG_ONCE) || (code == `CODE_ERASE_ALL) ||
            (code == `CODE_KEY_VERIFY) || (code == `CODE_ERASE_UNS);
    if (special && secure) begin
      code_allowed = (code == `CODE_ERASE_ALL) ||
                     (code == `CODE_ERASE_UNS);
    end else begin
      code_allowed = known;
    end
  endfunction

  assign command_code_byte = command_object_bytes[`COB_CODE];
  assign array_record = command_object_bytes[`COB_INDEX][3:0];
  assign array_wdata  = {command_object_bytes[`COB_DATA0 + 3],
                         command_object_bytes[`COB_DATA0 + 2],
                         command_object_bytes[`COB_DATA0 + 1],
                         command_object_bytes[`COB_DATA0]};
  assign supplied_key = gather_key(
    command_object_bytes[`COB_KEY0],     command_object_bytes[`COB_KEY0 + 1],
    command_object_bytes[`COB_KEY0 + 2], command_object_bytes[`COB_KEY0 + 3],
    command_object_bytes[`COB_KEY0 + 4], command_object_bytes[`COB_KEY0 + 5],
    command_object_bytes[`COB_KEY0 + 6], command_object_bytes[`COB_KEY0 + 7]);
  assign key_match  = (supplied_key == stored_backdoor_key);
  assign sec_secure = (security_state_field != `SEC_UNSECURE);
  assign launch = command_complete_flag_clear && command_complete_flag &&
                  (state == flash_cmd_pkg::ST_IDLE);
  // Rising pin edge only accepted while the engine is quiet
  assign ext_launch = ext_sync && !ext_prev && command_complete_flag &&
                      (state == flash_cmd_pkg::ST_IDLE) && !launch &&
                      !access_error_flag && !protection_violation_flag &&
                      (command_code_byte != `CODE_ERASE_ALL);

  always_comb begin
    next_state      = state;
    next_after_wait = after_wait;
    next_array_op   = array_op;
    next_command_complete_flag       = command_complete_flag;
    next_access_error_flag     = access_error_flag && !access_error_flag_clear;
    next_protection_violation_flag     = protection_violation_flag && !protection_violation_flag_clear;
    next_mgstat     = verify_fail_flag;
    next_erase_all_request_flag    = erase_all_request_flag;
    next_sec        = security_state_field;
    next_lockout    = key_lockout;
    next_ext_run    = ext_run;
    next_start      = 1'b0;
    next_rd_inv     = read_invalid;
    for (int i = 0; i < COB_BYTES; i++) begin
      next_cob[i] = command_object_bytes[i];
    end
    // Bytes frozen while a command runs
    if (cob_write && command_complete_flag &&
        (int'(cob_index) < COB_BYTES)) begin
      next_cob[cob_index] = cob_wdata;
    end
    unique case (state)
      flash_cmd_pkg::ST_RESET: begin
        next_sec  = stored_security_byte[`SEC_LSB +: 2];
        next_command_complete_flag = 1'b1;
        next_state = flash_cmd_pkg::ST_IDLE;
      end
      flash_cmd_pkg::ST_IDLE: begin
        if (launch) begin
          next_command_complete_flag   = 1'b0;
          next_mgstat = 1'b0;
          next_state  = flash_cmd_pkg::ST_DONE;
          if (!code_allowed(command_code_byte, nvm_special_mode,
                            sec_secure)) begin
            next_access_error_flag = 1'b1;
          end else if (command_code_byte == `CODE_PROG_ONCE) begin
            if (command_object_bytes[`COB_INDEX] > `MAX_RECORD) begin
              next_access_error_flag = 1'b1;
            end else begin
              next_rd_inv   = 1'b1;
              next_array_op = flash_cmd_pkg::OP_READ_REC;
              next_start    = 1'b1;
              next_after_wait = flash_cmd_pkg::ST_RD_REC;
              next_state    = flash_cmd_pkg::ST_WAIT;
            end
          end else if (command_code_byte == `CODE_KEY_VERIFY) begin
            if (!backdoor_key_enable || key_lockout) begin
              next_access_error_flag = 1'b1;
            end else if ((supplied_key == 64'h0) ||
                         (supplied_key == {64{1'b1}})) begin
              next_access_error_flag = 1'b1;
            end else if (key_match) begin
              next_sec = `SEC_UNSECURE;
            end else begin
              next_access_error_flag  = 1'b1;
              next_lockout = 1'b1;
            end
          end else if ((command_code_byte == `CODE_ERASE_ALL) &&
                       any_region_protected) begin
            next_protection_violation_flag = 1'b1;
          end else begin
            next_array_op = flash_cmd_pkg::OP_ERASE_ALL;
            next_start    = 1'b1;
            next_after_wait = flash_cmd_pkg::ST_ERASE;
            next_state    = flash_cmd_pkg::ST_WAIT;
          end
        end else if (ext_launch) begin
          // Protection is not consulted on this path
          next_command_complete_flag     = 1'b0;
          next_mgstat   = 1'b0;
          next_erase_all_request_flag  = 1'b1;
          next_ext_run  = 1'b1;
          next_array_op = flash_cmd_pkg::OP_ERASE_ALL;
          next_start    = 1'b1;
          next_after_wait = flash_cmd_pkg::ST_ERASE;
          next_state    = flash_cmd_pkg::ST_WAIT;
        end
      end
      flash_cmd_pkg::ST_WAIT: begin
        if (array_done) begin
          next_state = after_wait;
        end
      end
      flash_cmd_pkg::ST_RD_REC: begin
        if (array_rdata != `ERASED_WORD) begin
          next_access_error_flag = 1'b1;
          next_state  = flash_cmd_pkg::ST_DONE;
        end else begin
          next_array_op = flash_cmd_pkg::OP_PROG_REC;
          next_start    = 1'b1;
          next_after_wait = flash_cmd_pkg::ST_PROG;
          next_state    = flash_cmd_pkg::ST_WAIT;
        end
      end
      flash_cmd_pkg::ST_PROG: begin
        next_array_op = flash_cmd_pkg::OP_READ_REC;
        next_start    = 1'b1;
        next_after_wait = flash_cmd_pkg::ST_PROG_VFY;
        next_state    = flash_cmd_pkg::ST_WAIT;
      end
      flash_cmd_pkg::ST_PROG_VFY: begin
        if (array_fail || (array_rdata != array_wdata)) begin
          next_mgstat = 1'b1;
        end
        next_state = flash_cmd_pkg::ST_DONE;
      end
      flash_cmd_pkg::ST_ERASE: begin
        next_array_op = flash_cmd_pkg::OP_VFY_ALL;
        next_start    = 1'b1;
        next_after_wait = flash_cmd_pkg::ST_ERS_VFY;
        next_state    = flash_cmd_pkg::ST_WAIT;
      end
      flash_cmd_pkg::ST_ERS_VFY: begin
        next_state = flash_cmd_pkg::ST_DONE;
        if (array_fail) begin
          next_mgstat = 1'b1;
        end else begin
          next_sec = `SEC_UNSECURE;
          if (ext_run || (command_code_byte == `CODE_ERASE_UNS)) begin
            next_array_op = flash_cmd_pkg::OP_PROG_SEC;
            next_start    = 1'b1;
            next_after_wait = flash_cmd_pkg::ST_PROG_SEC;
            next_state    = flash_cmd_pkg::ST_WAIT;
          end
        end
      end
      flash_cmd_pkg::ST_PROG_SEC: begin
        if (array_fail) begin
          next_mgstat = 1'b1;
        end
        next_state = flash_cmd_pkg::ST_DONE;
      end
      flash_cmd_pkg::ST_DONE: begin
        next_command_complete_flag     = 1'b1;
        next_erase_all_request_flag  = 1'b0;
        next_ext_run  = 1'b0;
        next_rd_inv   = 1'b0;
        next_array_op = flash_cmd_pkg::OP_NONE;
        next_state    = flash_cmd_pkg::ST_IDLE;
      end
      default: begin
        next_state = flash_cmd_pkg::ST_RESET;
      end
    endcase
  end

  // Pin passes two flops; edge detect compares the second with a third flop, ext_prev
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else if (ce) begin
      ext_meta <= ext_erase_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Reset aborts any command and holds completion clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state                     <= flash_cmd_pkg::ST_RESET;
      after_wait                <= flash_cmd_pkg::ST_DONE;
      array_op                  <= flash_cmd_pkg::OP_NONE;
      command_complete_flag     <= 1'b0;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_fail_flag          <= 1'b0;
      erase_all_request_flag    <= 1'b0;
      security_state_field      <= `SEC_RESET;
      key_lockout               <= 1'b0;
      ext_run                   <= 1'b0;
      array_start               <= 1'b0;
      read_invalid              <= 1'b0;
      for (int i = 0; i < COB_BYTES; i++) begin
        command_object_bytes[i] <= 8'h00;
      end
    end else if (ce) begin
      state                     <= next_state;
      after_wait                <= next_after_wait;
      array_op                  <= next_array_op;
      command_complete_flag     <= next_command_complete_flag;
      access_error_flag         <= next_access_error_flag;
      protection_violation_flag <= next_protection_violation_flag;
      verify_fail_flag          <= next_mgstat;
      erase_all_request_flag    <= next_erase_all_request_flag;
      security_state_field      <= next_sec;
      key_lockout               <= next_lockout;
      ext_run                   <= next_ext_run;
      array_start               <= next_start;
      read_invalid              <= next_rd_inv;
      for (int i = 0; i < COB_BYTES; i++) begin
        command_object_bytes[i] <= next_cob[i];
      end
    end
  end

  // Enable field comes from the stored byte, not the live security state
  logic backdoor_key_enable_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      backdoor_key_enable_reg <= 1'b0;
    end else if (ce && (state == flash_cmd_pkg::ST_RESET)) begin
      backdoor_key_enable_reg <= (stored_security_byte[`BACKDOOR_KEY_ENABLE_LSB +: 2] ==
                    `BACKDOOR_KEY_ENABLE_ENABLED);
    end
  end
  assign backdoor_key_enable = backdoor_key_enable_reg;

endmodule
`default_nettype wire

// ### tb/flash_engine_chk.sv
// Purpose: Port-level checks for the flash special command engine.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound onto every engine instance.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"
module flash_engine_chk (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        command_complete_flag_clear,
  input wire logic        nvm_special_mode,
  input wire logic        any_region_protected,
  input wire logic        array_done,
  input wire logic [31:0] array_rdata,
  input wire logic        command_complete_flag,
  input wire logic        protection_violation_flag,
  input wire logic        erase_all_request_flag,
  input wire logic [1:0]  security_state_field,
  input wire logic        read_invalid,
  input wire logic        array_start,
  input wire flash_cmd_pkg::array_op_t array_op,
  input wire logic [7:0]  command_code_byte
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_go(logic [7:0] c);
    command_complete_flag_clear && command_complete_flag && command_code_byte == c &&
      !nvm_special_mode;
  endsequence

  chk_launch_clear: assert property (
    command_complete_flag_clear && command_complete_flag |=> !command_complete_flag)
    else $error("complete flag stayed set after launch");
  chk_no_self_start: assert property (
    $fell(command_complete_flag) |->
      $past(command_complete_flag_clear) || erase_all_request_flag)
    else $error("command started without a launch");
  chk_erase_start: assert property (
    s_go(`CODE_ERASE_ALL) ##0 !any_region_protected |=>
      array_start && array_op == flash_cmd_pkg::OP_ERASE_ALL)
    else $error("whole erase did not start the array");
  chk_protect_abort: assert property (
    s_go(`CODE_ERASE_ALL) ##0 any_region_protected |=>
      !array_start ##1 (protection_violation_flag && command_complete_flag))
    else $error("protected whole erase not aborted");
  chk_key_quick: assert property (
    s_go(`CODE_KEY_VERIFY) |=> !array_start ##1 command_complete_flag)
    else $error("key verify did not finish at once");
  chk_prog_erased: assert property (
    array_start && array_op == flash_cmd_pkg::OP_PROG_REC |->
      $past(array_done, 2) && $past(array_rdata) == `ERASED_WORD &&
      read_invalid)
    else $error("record programmed without erased read");
  chk_ext_busy: assert property (
    erase_all_request_flag |-> !command_complete_flag)
    else $error("complete flag set during external erase");
  chk_ext_end: assert property (
    $fell(erase_all_request_flag) |-> $rose(command_complete_flag))
    else $error("request flag and complete flag out of step");
  chk_sec_change: assert property (
    $changed(security_state_field) |->
      !$past(command_complete_flag) || $past(command_complete_flag_clear) || !$past(rst_n))
    else $error("security changed outside a command");
  chk_reset_idle: assert property (
    @(posedge mclk) disable iff (1'b0)
    !rst_n |-> !command_complete_flag && security_state_field == `SEC_RESET)
    else $error("flags not held during reset");
endmodule

bind flash_special_command_engine flash_engine_chk i_flash_engine_chk (
  .mclk(mclk), .rst_n(rst_n), .command_complete_flag_clear(command_complete_flag_clear),
  .nvm_special_mode(nvm_special_mode),
  .any_region_protected(any_region_protected), .array_done(array_done),
  .array_rdata(array_rdata), .command_complete_flag(command_complete_flag),
  .protection_violation_flag(protection_violation_flag),
  .erase_all_request_flag(erase_all_request_flag),
  .security_state_field(security_state_field), .read_invalid(read_invalid),
  .array_start(array_start), .array_op(array_op),
  .command_code_byte(command_code_byte));
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the flash special command engine.
// Assumes: Array controller answers in the same cycle as each start.
// Notes:   The bench stands in for the array controller itself.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"
module tb_top;
  logic        mclk = '0, rst_n = '1, ce = '1, cob_write = '0;
  logic        command_complete_flag_clear = '0, access_error_flag_clear = '0, protection_violation_flag_clear = '0;
  logic        nvm_special_mode = '0, any_region_protected = '0;
  logic        ext_erase_pin = '0, array_done = '0, array_fail = '0;
  logic        fl = '0, bad = '0, ri = '0;
  logic [3:0]  cob_index = '0;
  logic [7:0]  cob_wdata = '0, stored_security_byte = 8'hBF, seen = '0;
  logic [63:0] stored_backdoor_key = 64'h0123456789ABCDEF;
  logic [31:0] array_rdata = '0, mem = '0;
  logic        command_complete_flag, access_error_flag, verify_fail_flag;
  logic        protection_violation_flag, erase_all_request_flag;
  logic        backdoor_key_enable, read_invalid, array_start;
  logic [1:0]  security_state_field;
  logic [3:0]  array_record;
  logic [31:0] array_wdata;
  logic [7:0]  command_code_byte;
  flash_cmd_pkg::array_op_t array_op;
  int          miscompares = 0, checks_done = 0;

  flash_special_command_engine i_flash_special_command_engine (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .cob_write(cob_write),
    .cob_index(cob_index), .cob_wdata(cob_wdata), .command_complete_flag_clear(command_complete_flag_clear),
    .access_error_flag_clear(access_error_flag_clear), .protection_violation_flag_clear(protection_violation_flag_clear),
    .nvm_special_mode(nvm_special_mode),
    .any_region_protected(any_region_protected),
    .stored_security_byte(stored_security_byte),
    .stored_backdoor_key(stored_backdoor_key),
    .ext_erase_pin(ext_erase_pin), .array_done(array_done),
    .array_fail(array_fail), .array_rdata(array_rdata),
    .command_complete_flag(command_complete_flag),
    .access_error_flag(access_error_flag),
    .protection_violation_flag(protection_violation_flag),
    .verify_fail_flag(verify_fail_flag),
    .erase_all_request_flag(erase_all_request_flag),
    .security_state_field(security_state_field),
    .backdoor_key_enable(backdoor_key_enable),
    .read_invalid(read_invalid), .array_start(array_start),
    .array_op(array_op), .array_record(array_record),
    .array_wdata(array_wdata), .command_code_byte(command_code_byte));

  always #12.5 mclk = ~mclk;

  // Record store: a bad cell keeps its old value, so readback fails
  // Fail holds until the next start; the engine reads it after done
  always @(posedge mclk) begin
    #1;
    array_done = array_start;
    if (array_start) array_fail = fl;
    array_rdata = mem;
    if (array_start) seen[array_op] = '1;
    if (array_start && array_op == flash_cmd_pkg::OP_PROG_REC && !bad)
      mem = array_wdata;
    if (read_invalid) ri = '1;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic ck(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      $display("MISMATCH %0t %s", $time, m);
      miscompares++;
    end
  endtask

  task automatic st(input logic a, p, v, input logic [1:0] s, string m);
    ck(access_error_flag === a && protection_violation_flag === p &&
       verify_fail_flag === v && security_state_field === s, m);
  endtask

  task automatic wt;
    int n;
    n = 0;
    while (command_complete_flag !== 1'h1) begin
      @(posedge mclk) #1;
      n++;
      if (n > 200) begin
        ck('0, "timeout");
        close_out;
      end
    end
  endtask

  task automatic rst(input logic [7:0] sb);
    stored_security_byte = sb;
    rst_n = '0;
    repeat (20) @(posedge mclk);
    #1 ck(command_complete_flag === '0, "flag in reset");
    rst_n = '1;
    repeat (2) @(posedge mclk);
    #1 ck(command_complete_flag === '1 && security_state_field === sb[1:0]
       && backdoor_key_enable === (sb[7:6] == 2'h2), "load");
  endtask

  // Error flags are cleared while the bytes load
  task automatic ld(input logic [7:0] c, i, input logic [63:0] d);
    for (int k = 0; k < 12; k++) begin
      cob_index = k[3:0];
      cob_wdata = k == 0 ? c : k == 1 ? i : k < 4 ? 8'hA5 : d[8*(k-4) +: 8];
      access_error_flag_clear = k == 0;
      protection_violation_flag_clear = k == 0;
      cob_write = '1;
      @(posedge mclk) #1;
    end
    cob_write = '0;
  endtask

  task automatic cmd(input logic [7:0] c, i, input logic [63:0] d);
    seen = '0;
    ri = '0;
    ld(c, i, d);
    command_complete_flag_clear = '1;
    @(posedge mclk) #1 command_complete_flag_clear = '0;
    wt;
  endtask

  function automatic logic [63:0] sw(input logic [63:0] k);
    for (int j = 0; j < 8; j++)
      sw[8*j +: 8] = k[8*((j/4)*4 + 3 - j%4) +: 8];
  endfunction

  task automatic t_otp;
    mem = `ERASED_WORD;
    cmd(`CODE_PROG_ONCE, `MAX_RECORD, 64'h12345678);
    st('0, '0, '0, 2'h3, "otp pass");
    ck(mem === 32'h12345678 && array_record === 4'hF && ri === '1 &&
       seen === 8'h06, "otp steps");
    cmd(`CODE_PROG_ONCE, `MAX_RECORD, 64'h0);
    ck(access_error_flag === '1 && seen === 8'h02, "otp used");
    cmd(`CODE_PROG_ONCE, 8'h10, 64'h0);
    ck(access_error_flag === '1 && seen === 8'h00, "otp index");
    mem = `ERASED_WORD;
    bad = '1;
    cmd(`CODE_PROG_ONCE, 8'h00, 64'h5A5A5A5A);
    st('0, '0, '1, 2'h3, "otp verify");
    bad = '0;
  endtask

  task automatic t_erase;
    any_region_protected = '1;
    cmd(`CODE_ERASE_ALL, 8'h00, '0);
    ck(protection_violation_flag === '1 && seen === '0, "prot");
    any_region_protected = '0;
    cmd(`CODE_ERASE_ALL, 8'h00, '0);
    st('0, '0, '0, `SEC_UNSECURE, "erase all");
    ck(seen === 8'h18, "erase ops");
  endtask

  task automatic t_eu;
    rst(8'hBF);
    fl = '1;
    cmd(`CODE_ERASE_UNS, 8'h00, '0);
    st('0, '0, '1, 2'h3, "eu fail");
    fl = '0;
    cmd(`CODE_ERASE_UNS, 8'h00, '0);
    st('0, '0, '0, `SEC_UNSECURE, "eu pass");
    ck(seen === 8'h38, "eu ops");
  endtask

  task automatic t_key;
    logic [63:0] k;
    k = sw(stored_backdoor_key);
    rst(8'hFF);
    cmd(`CODE_KEY_VERIFY, 8'h00, k);
    st('1, '0, '0, 2'h3, "key off");
    rst(8'hBF);
    cmd(`CODE_KEY_VERIFY, 8'h00, '0);
    st('1, '0, '0, 2'h3, "key zeros");
    cmd(`CODE_KEY_VERIFY, 8'h00, '1);
    st('1, '0, '0, 2'h3, "key ones");
    cmd(`CODE_KEY_VERIFY, 8'h00, k ^ 64'h1);
    st('1, '0, '0, 2'h3, "key wrong");
    cmd(`CODE_KEY_VERIFY, 8'h00, k);
    st('1, '0, '0, 2'h3, "key locked");
    rst(8'hBF);
    cmd(`CODE_KEY_VERIFY, 8'h00, k);
    st('0, '0, '0, `SEC_UNSECURE, "key match");
    rst(8'hBF);
  endtask

  task automatic t_mode;
    nvm_special_mode = '1;
    cmd(`CODE_PROG_ONCE, 8'h00, '0);
    st('1, '0, '0, 2'h3, "mode refuse");
    cmd(`CODE_ERASE_ALL, 8'h00, '0);
    st('0, '0, '0, `SEC_UNSECURE, "mode allow");
    nvm_special_mode = '0;
  endtask

  task automatic t_busy;
    ld(`CODE_ERASE_ALL, 8'h00, '0);
    command_complete_flag_clear = '1;
    @(posedge mclk) #1 command_complete_flag_clear = '0;
    cob_index = 4'h0;
    cob_wdata = `CODE_PROG_ONCE;
    cob_write = '1;
    @(posedge mclk) #1 cob_write = '0;
    wt;
    ck(command_code_byte === `CODE_ERASE_ALL, "busy write");
  endtask

  task automatic t_ext;
    int n;
    rst(8'hBF);
    ld(8'h00, 8'h00, '0);
    seen = '0;
    any_region_protected = '1;
    ext_erase_pin = '1;
    n = 0;
    while (erase_all_request_flag !== '1 && n < 10) begin
      @(posedge mclk) #1;
      n++;
    end
    ck(command_complete_flag === '0 && n < 10, "ext start");
    wt;
    ext_erase_pin = '0;
    ck(erase_all_request_flag === '0 && seen === 8'h38, "ext ops");
    st('0, '0, '0, `SEC_UNSECURE, "ext end");
    any_region_protected = '0;
  endtask

  task automatic t_abort;
    ld(`CODE_ERASE_ALL, 8'h00, '0);
    command_complete_flag_clear = '1;
    @(posedge mclk) #1 command_complete_flag_clear = '0;
    rst(8'hBF);
    seen = '0;
    repeat (5) @(posedge mclk);
    #1 ck(seen === '0 && command_complete_flag === '1, "resume");
  endtask

  initial begin
    // Real falling edge so the asynchronous reset fires before mclk
    #1;
    rst(8'hBF);
    t_otp;
    t_erase;
    t_eu;
    t_key;
    t_mode;
    t_busy;
    t_ext;
    t_abort;
    close_out;
  end
endmodule
`default_nettype wire
